// file: core/irwd_defines.svh
// register offsets, field positions, reset values and timing counts of the ir wake decoder
`ifndef IRWD_DEFINES_SVH
`define IRWD_DEFINES_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define IRWD_OFS_CONTROL 8'h13
`define IRWD_OFS_ADDRESS 8'h15
`define IRWD_OFS_MASK 8'h16
`define IRWD_OFS_RX_ADDRESS 8'h17
`define IRWD_OFS_W0_LOW 8'h18
`define IRWD_OFS_W0_HIGH 8'h19
`define IRWD_OFS_W1_LOW 8'h1A
`define IRWD_OFS_W1_HIGH 8'h1B
`define IRWD_OFS_W2_LOW 8'h1C
`define IRWD_OFS_W2_HIGH 8'h1D
`define IRWD_OFS_W3_LOW 8'h1E
`define IRWD_OFS_W3_HIGH 8'h1F

// ****************************************************************
// control fields and window write mask
// ****************************************************************
`define IRWD_CTL_EN_BIT 0
`define IRWD_CTL_INV_BIT 2
`define IRWD_CTL_SEL_BIT 3
`define IRWD_CTL_PROTO_LSB 4
`define IRWD_CTL_PROTO_MSB 5
`define IRWD_CTL_WR_MASK 8'h3D
`define IRWD_PROTO_RC5 2'h0
`define IRWD_PROTO_PDIST 2'h1
`define IRWD_WIN_NARROW_MASK 8'h1F

// ****************************************************************
// reset values
// ****************************************************************
`define IRWD_RST_CONTROL 8'h00
`define IRWD_RST_ADDRESS 8'h00
`define IRWD_RST_MASK 8'hE0
`define IRWD_RST_RX_ADDRESS 8'h00
`define IRWD_RST_W0_LOW 8'h10
`define IRWD_RST_W0_HIGH 8'h14
`define IRWD_RST_W1_LOW 8'h07
`define IRWD_RST_W1_HIGH 8'h0B
`define IRWD_RST_W2_LOW 8'h50
`define IRWD_RST_W2_HIGH 8'h64
`define IRWD_RST_W3_LOW 8'h28
`define IRWD_RST_W3_HIGH 8'h32

// ****************************************************************
// timing and message layout
// ****************************************************************
`define IRWD_CLK_PERIOD_NS 10
`define IRWD_TICK_TIME_NS 100000
`define IRWD_TICK_CYCLES (`IRWD_TICK_TIME_NS / `IRWD_CLK_PERIOD_NS)
`define IRWD_WIDTH_SAT 8'hFF
`define IRWD_RC5_ADDR_FIRST 4'h3
`define IRWD_RC5_ADDR_LAST 4'h7
`define IRWD_PDIST_ADDR_LAST 4'h7

`endif

// file: core/irwd_pkg.sv
// types shared by the ir wake decoder modules
package irwd_pkg;

    typedef enum logic [5:0] {
        ST_SEARCH = 6'h01,
        ST_PD_HDR = 6'h02,
        ST_PD_GAP = 6'h04,
        ST_PD_BITS = 6'h08,
        ST_RC5_BITS = 6'h10,
        ST_QUIET = 6'h20
    } irwd_state_t;

    typedef struct packed {
        logic [7:0] control;
        logic [7:0] address;
        logic [7:0] mask;
        logic [7:0] rx_address;
        logic [7:0] w0_low;
        logic [7:0] w0_high;
        logic [7:0] w1_low;
        logic [7:0] w1_high;
        logic [7:0] w2_low;
        logic [7:0] w2_high;
        logic [7:0] w3_low;
        logic [7:0] w3_high;
        irwd_state_t state;
        logic [4:0] half;
        logic [3:0] nbits;
        logic [7:0] high_width;
        logic [7:0] rdata;
        logic match;
        logic busy;
    } irwd_core_t;

    typedef struct packed {
        logic [1:0] sync1;
        logic [1:0] sync2;
        logic [1:0] sync3;
        logic [1:0] stable;
        logic level;
        logic [15:0] prescale;
        logic [7:0] count;
        logic edge_seen;
        logic seg_level;
        logic [7:0] width;
    } irwd_meter_t;

endpackage

// file: core/irwd_meter_if.sv
// link between the decoder core and the pulse meter
`timescale 1ns/10ps
interface irwd_meter_if;
    logic sel_b;
    logic invert;
    logic edge_seen;
    logic level;
    logic [7:0] width;
    logic sat;

    modport core (output sel_b, output invert,
                  input edge_seen, input level, input width, input sat);
    modport meter (input sel_b, input invert,
                   output edge_seen, output level, output width, output sat);
endinterface

// file: core/irwd_meter.sv
// input conditioning and segment width meter in 0.1 ms ticks
`timescale 1ns/10ps
`include "irwd_defines.svh"
module irwd_meter #(
    parameter int TICK_CYCLES = `IRWD_TICK_CYCLES
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic soft_rst_in,
    input wire logic ce_in,
    input wire logic rx_a_in,
    input wire logic rx_b_in,
    irwd_meter_if.meter mi
);
    localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

    irwd_pkg::irwd_meter_t cur_ff;
    irwd_pkg::irwd_meter_t nxt_ff;
    logic sel_level;
    logic line_level;

    always_comb begin
        nxt_ff = cur_ff;
        nxt_ff.sync1 = {rx_b_in, rx_a_in};
        nxt_ff.sync2 = cur_ff.sync1;
        nxt_ff.sync3 = cur_ff.sync2;
        // a change counts only once the second and third stages agree
        nxt_ff.stable = (cur_ff.sync2 & ~(cur_ff.sync2 ^ cur_ff.sync3))
                      | (cur_ff.stable & (cur_ff.sync2 ^ cur_ff.sync3));
        sel_level = mi.sel_b ? cur_ff.stable[1] : cur_ff.stable[0];
        line_level = sel_level ^ mi.invert;
        nxt_ff.edge_seen = 1'b0;
        if (line_level != cur_ff.level) begin
            nxt_ff.level = line_level;
            nxt_ff.edge_seen = 1'b1;
            nxt_ff.seg_level = cur_ff.level;
            nxt_ff.width = cur_ff.count;
            nxt_ff.count = 8'h00;
            nxt_ff.prescale = 16'h0000;
        end else if (cur_ff.prescale == TICK_LAST) begin
            nxt_ff.prescale = 16'h0000;
            if (cur_ff.count != `IRWD_WIDTH_SAT) begin
                nxt_ff.count = cur_ff.count + 8'h01;
            end
        end else begin
            nxt_ff.prescale = cur_ff.prescale + 16'h0001;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in || soft_rst_in) begin
            cur_ff <= '0;
        end else if (ce_in) begin
            cur_ff <= nxt_ff;
        end
    end

    assign mi.edge_seen = cur_ff.edge_seen;
    assign mi.level = cur_ff.seg_level;
    assign mi.width = cur_ff.width;
    assign mi.sat = (cur_ff.count == `IRWD_WIDTH_SAT);
endmodule

// file: core/irwd_top.sv
// ir remote wake-up decoder: registers, protocol decoding and address match
//
// Implementation choice: strobed register access.
`timescale 1ns/10ps
`include "irwd_defines.svh"

module irwd_top #(
    parameter int TICK_CYCLES = `IRWD_TICK_CYCLES
) (
    input wire logic CLK_SYS_IN,
    input wire logic RST_N_IN,
    input wire logic CE_IN,
    input wire logic SOFT_RST_IN,
    input wire logic [7:0] REG_ADDR_IN,
    input wire logic [7:0] REG_WDATA_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    input wire logic IR_RECEIVE_INPUT_A_IN,
    input wire logic IR_RECEIVE_INPUT_B_IN,
    output logic [7:0] REG_RDATA_OUT,
    output logic IR_WAKE_MATCH_OUT,
    output logic IR_DECODER_BUSY_OUT
);

    // ****************************************************************
    // constants and helpers
    // ****************************************************************
    localparam irwd_pkg::irwd_core_t CORE_RESET = '{
        control: `IRWD_RST_CONTROL,
        address: `IRWD_RST_ADDRESS,
        mask: `IRWD_RST_MASK,
        rx_address: `IRWD_RST_RX_ADDRESS,
        w0_low: `IRWD_RST_W0_LOW,
        w0_high: `IRWD_RST_W0_HIGH,
        w1_low: `IRWD_RST_W1_LOW,
        w1_high: `IRWD_RST_W1_HIGH,
        w2_low: `IRWD_RST_W2_LOW,
        w2_high: `IRWD_RST_W2_HIGH,
        w3_low: `IRWD_RST_W3_LOW,
        w3_high: `IRWD_RST_W3_HIGH,
        state: irwd_pkg::ST_SEARCH,
        half: 5'h00,
        nbits: 4'h0,
        high_width: 8'h00,
        rdata: 8'h00,
        match: 1'b0,
        busy: 1'b0
    };

    // inclusive limits; a 9-bit width covers summed pulse-distance intervals
    function automatic logic in_window(input logic [8:0] w, input logic [7:0] lo,
                                       input logic [7:0] hi);
        in_window = (w >= {1'b0, lo}) && (w <= {1'b0, hi});
    endfunction

    function automatic logic masked_equal(input logic [7:0] rx, input logic [7:0] ref_addr,
                                          input logic [7:0] msk);
        masked_equal = (((rx ^ ref_addr) & ~msk) == 8'h00);
    endfunction

    irwd_pkg::irwd_core_t cur_ff;
    irwd_pkg::irwd_core_t nxt_ff;
    irwd_meter_if mi ();

    logic rise;
    logic fall;
    logic [8:0] seg_w;
    logic [8:0] interval;
    logic fit_w0;
    logic fit_w1;
    logic [1:0] proto;
    logic enabled;
    logic [3:0] bit_idx;
    logic [7:0] shifted;

    // ****************************************************************
    // pulse meter
    // ****************************************************************
    irwd_meter #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_meter (
        .clk_in(CLK_SYS_IN),
        .rst_n_in(RST_N_IN),
        .soft_rst_in(SOFT_RST_IN),
        .ce_in(CE_IN),
        .rx_a_in(IR_RECEIVE_INPUT_A_IN),
        .rx_b_in(IR_RECEIVE_INPUT_B_IN),
        .mi(mi.meter)
    );

    assign mi.sel_b = cur_ff.control[`IRWD_CTL_SEL_BIT];
    assign mi.invert = cur_ff.control[`IRWD_CTL_INV_BIT];

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        nxt_ff = cur_ff;
        nxt_ff.match = 1'b0;
        nxt_ff.rdata = 8'h00;
        proto = cur_ff.control[`IRWD_CTL_PROTO_MSB:`IRWD_CTL_PROTO_LSB];
        enabled = cur_ff.control[`IRWD_CTL_EN_BIT];
        // a rising edge ends a low segment, a falling edge a high one
        rise = mi.edge_seen && !mi.level;
        fall = mi.edge_seen && mi.level;
        seg_w = {1'b0, mi.width};
        interval = {1'b0, cur_ff.high_width} + seg_w;
        fit_w0 = 1'b0;
        fit_w1 = 1'b0;
        bit_idx = cur_ff.half[4:1];
        shifted = cur_ff.rx_address;

        // register writes; reserved bits are stored as zero
        if (REG_WR_IN) begin
            unique case (REG_ADDR_IN)
                `IRWD_OFS_CONTROL: nxt_ff.control = REG_WDATA_IN & `IRWD_CTL_WR_MASK;
                `IRWD_OFS_ADDRESS: nxt_ff.address = REG_WDATA_IN;
                `IRWD_OFS_MASK: nxt_ff.mask = REG_WDATA_IN;
                `IRWD_OFS_W0_LOW: nxt_ff.w0_low = REG_WDATA_IN & `IRWD_WIN_NARROW_MASK;
                `IRWD_OFS_W0_HIGH: nxt_ff.w0_high = REG_WDATA_IN & `IRWD_WIN_NARROW_MASK;
                `IRWD_OFS_W1_LOW: nxt_ff.w1_low = REG_WDATA_IN & `IRWD_WIN_NARROW_MASK;
                `IRWD_OFS_W1_HIGH: nxt_ff.w1_high = REG_WDATA_IN & `IRWD_WIN_NARROW_MASK;
                `IRWD_OFS_W2_LOW: nxt_ff.w2_low = REG_WDATA_IN;
                `IRWD_OFS_W2_HIGH: nxt_ff.w2_high = REG_WDATA_IN;
                `IRWD_OFS_W3_LOW: nxt_ff.w3_low = REG_WDATA_IN;
                `IRWD_OFS_W3_HIGH: nxt_ff.w3_high = REG_WDATA_IN;
                default: nxt_ff.control = cur_ff.control;
            endcase
        end

        // read data stand only in the cycle after the strobe
        if (REG_RD_IN) begin
            unique case (REG_ADDR_IN)
                `IRWD_OFS_CONTROL: nxt_ff.rdata = cur_ff.control;
                `IRWD_OFS_ADDRESS: nxt_ff.rdata = cur_ff.address;
                `IRWD_OFS_MASK: nxt_ff.rdata = cur_ff.mask;
                `IRWD_OFS_RX_ADDRESS: nxt_ff.rdata = cur_ff.rx_address;
                `IRWD_OFS_W0_LOW: nxt_ff.rdata = cur_ff.w0_low;
                `IRWD_OFS_W0_HIGH: nxt_ff.rdata = cur_ff.w0_high;
                `IRWD_OFS_W1_LOW: nxt_ff.rdata = cur_ff.w1_low;
                `IRWD_OFS_W1_HIGH: nxt_ff.rdata = cur_ff.w1_high;
                `IRWD_OFS_W2_LOW: nxt_ff.rdata = cur_ff.w2_low;
                `IRWD_OFS_W2_HIGH: nxt_ff.rdata = cur_ff.w2_high;
                `IRWD_OFS_W3_LOW: nxt_ff.rdata = cur_ff.w3_low;
                `IRWD_OFS_W3_HIGH: nxt_ff.rdata = cur_ff.w3_high;
                default: nxt_ff.rdata = 8'h00;
            endcase
        end

        // ************************************************************
        // decoder
        // ************************************************************
        unique case (cur_ff.state)
            irwd_pkg::ST_SEARCH: begin
                if (rise && proto == `IRWD_PROTO_RC5) begin
                    // the first half of start bit is idle-low and unseen
                    nxt_ff.state = irwd_pkg::ST_RC5_BITS;
                    nxt_ff.half = 5'h01;
                    nxt_ff.rx_address = 8'h00;
                end else if (rise && proto == `IRWD_PROTO_PDIST) begin
                    nxt_ff.state = irwd_pkg::ST_PD_HDR;
                end
            end
            irwd_pkg::ST_PD_HDR: begin
                if (fall) begin
                    if (in_window(seg_w, cur_ff.w2_low, cur_ff.w2_high)) begin
                        nxt_ff.state = irwd_pkg::ST_PD_GAP;
                    end else begin
                        nxt_ff.state = irwd_pkg::ST_SEARCH;
                    end
                end
            end
            irwd_pkg::ST_PD_GAP: begin
                if (rise) begin
                    if (in_window(seg_w, cur_ff.w3_low, cur_ff.w3_high)) begin
                        nxt_ff.state = irwd_pkg::ST_PD_BITS;
                        nxt_ff.nbits = 4'h0;
                    end else begin
                        nxt_ff.state = irwd_pkg::ST_SEARCH;
                    end
                end
            end
            irwd_pkg::ST_PD_BITS: begin
                if (fall) begin
                    nxt_ff.high_width = mi.width;
                end else if (rise) begin
                    fit_w0 = in_window(interval, cur_ff.w0_low, cur_ff.w0_high);
                    fit_w1 = in_window(interval, cur_ff.w1_low, cur_ff.w1_high);
                    if (!fit_w0 && !fit_w1) begin
                        nxt_ff.state = irwd_pkg::ST_SEARCH;
                    end else begin
                        // address arrives least significant bit first
                        shifted = {fit_w1 && !fit_w0, cur_ff.rx_address[7:1]};
                        nxt_ff.rx_address = shifted;
                        nxt_ff.nbits = cur_ff.nbits + 4'h1;
                        if (cur_ff.nbits == `IRWD_PDIST_ADDR_LAST) begin
                            nxt_ff.match = enabled
                                && masked_equal(shifted, cur_ff.address, cur_ff.mask);
                            nxt_ff.state = irwd_pkg::ST_QUIET;
                        end
                    end
                end
            end
            irwd_pkg::ST_RC5_BITS: begin
                if (mi.edge_seen) begin
                    fit_w1 = in_window(seg_w, cur_ff.w1_low, cur_ff.w1_high);
                    fit_w0 = !fit_w1
                        && in_window(seg_w, cur_ff.w0_low, cur_ff.w0_high);
                    if (!fit_w0 && !fit_w1) begin
                        nxt_ff.state = irwd_pkg::ST_SEARCH;
                    end else begin
                        nxt_ff.half = cur_ff.half + (fit_w0 ? 5'h02 : 5'h01);
                        // the level of a cell's second half is the bit value
                        if ((cur_ff.half[0] || fit_w0) && bit_idx >= `IRWD_RC5_ADDR_FIRST) begin
                            shifted = {cur_ff.rx_address[6:0], mi.level};
                            nxt_ff.rx_address = shifted;
                            if (bit_idx == `IRWD_RC5_ADDR_LAST) begin
                                // top three bits stay masked by software in this mode
                                nxt_ff.match = enabled
                                    && masked_equal(shifted, cur_ff.address, cur_ff.mask);
                                nxt_ff.state = irwd_pkg::ST_QUIET;
                            end
                        end
                    end
                end
            end
            irwd_pkg::ST_QUIET: begin
                // command bits are ignored until the line rests
                nxt_ff.state = irwd_pkg::ST_QUIET;
            end
            default: nxt_ff.state = irwd_pkg::ST_SEARCH;
        endcase

        // a segment longer than the meter range ends any message
        if (mi.sat && cur_ff.state != irwd_pkg::ST_SEARCH) begin
            nxt_ff.state = irwd_pkg::ST_SEARCH;
        end
        nxt_ff.busy = (nxt_ff.state != irwd_pkg::ST_SEARCH);
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN || SOFT_RST_IN) begin
            cur_ff <= CORE_RESET;
        end else if (CE_IN) begin
            cur_ff <= nxt_ff;
        end
    end

    assign REG_RDATA_OUT = cur_ff.rdata;
    assign IR_WAKE_MATCH_OUT = cur_ff.match;
    assign IR_DECODER_BUSY_OUT = cur_ff.busy;
endmodule

// file: verif/irwd_top_props.sv
// concurrent checks on the ports of the ir wake decoder
`timescale 1ns/10ps
module irwd_top_props #(
    parameter int TICK_CYCLES = 4
) (
    input wire logic CLK_SYS_IN,
    input wire logic RST_N_IN,
    input wire logic CE_IN,
    input wire logic SOFT_RST_IN,
    input wire logic [7:0] REG_ADDR_IN,
    input wire logic [7:0] REG_WDATA_IN,
    input wire logic REG_WR_IN,
    input wire logic REG_RD_IN,
    input wire logic IR_RECEIVE_INPUT_A_IN,
    input wire logic IR_RECEIVE_INPUT_B_IN,
    input wire logic [7:0] REG_RDATA_OUT,
    input wire logic IR_WAKE_MATCH_OUT,
    input wire logic IR_DECODER_BUSY_OUT
);
    logic [7:0] ctl_ff;
    logic [7:0] msk_ff;
    default clocking cb @(posedge CLK_SYS_IN); endclocking
    default disable iff (!RST_N_IN || SOFT_RST_IN);
    // ****************************************************************
    // bus shadow of control and mask
    // ****************************************************************
    always_ff @(posedge CLK_SYS_IN) begin
        if (!RST_N_IN || SOFT_RST_IN) begin
            ctl_ff <= 8'h00;
            msk_ff <= 8'hE0;
        end else if (CE_IN && REG_WR_IN && REG_ADDR_IN == 8'h13) begin
            ctl_ff <= REG_WDATA_IN & 8'h3D;
        end else if (CE_IN && REG_WR_IN && REG_ADDR_IN == 8'h16) begin
            msk_ff <= REG_WDATA_IN;
        end
    end
    sequence s_rd(a);
        CE_IN && REG_RD_IN && REG_ADDR_IN == a;
    endsequence
    sequence s_pulse;
        IR_WAKE_MATCH_OUT ##1 !IR_WAKE_MATCH_OUT [*8];
    endsequence
    ctl_readback_a: assert property (s_rd(8'h13) |=> REG_RDATA_OUT == ctl_ff)
        else $error("control read differs");
    mask_readback_a: assert property (s_rd(8'h16) |=> REG_RDATA_OUT == msk_ff)
        else $error("mask read differs");
    win_reserved_a: assert property (CE_IN && REG_RD_IN && REG_ADDR_IN[7:1] == 7'h0C
        |=> REG_RDATA_OUT[7:5] == 3'h0) else $error("window upper bits set");
    unmapped_read_a: assert property (CE_IN && REG_RD_IN && (REG_ADDR_IN < 8'h13
        || REG_ADDR_IN > 8'h1F || REG_ADDR_IN == 8'h14) |=> REG_RDATA_OUT == 8'h00)
        else $error("unmapped read not zero");
    rdata_idle_a: assert property (CE_IN && !REG_RD_IN |=> REG_RDATA_OUT == 8'h00)
        else $error("read data outside read cycle");
    match_enable_a: assert property (IR_WAKE_MATCH_OUT |-> ctl_ff[0])
        else $error("match while disabled");
    match_single_a: assert property (IR_WAKE_MATCH_OUT |-> s_pulse)
        else $error("match pulse repeated");
    match_in_msg_a: assert property (IR_WAKE_MATCH_OUT |-> $past(IR_DECODER_BUSY_OUT))
        else $error("match outside message");
    proto_reserved_a: assert property (ctl_ff[5] |-> !IR_WAKE_MATCH_OUT)
        else $error("match with reserved protocol");
endmodule
bind irwd_top irwd_top_props #(.TICK_CYCLES(TICK_CYCLES)) irwd_top_props_i (
    .CLK_SYS_IN(CLK_SYS_IN), .RST_N_IN(RST_N_IN), .CE_IN(CE_IN),
    .SOFT_RST_IN(SOFT_RST_IN), .REG_ADDR_IN(REG_ADDR_IN), .REG_WDATA_IN(REG_WDATA_IN),
    .REG_WR_IN(REG_WR_IN), .REG_RD_IN(REG_RD_IN),
    .IR_RECEIVE_INPUT_A_IN(IR_RECEIVE_INPUT_A_IN), .IR_RECEIVE_INPUT_B_IN(IR_RECEIVE_INPUT_B_IN),
    .REG_RDATA_OUT(REG_RDATA_OUT), .IR_WAKE_MATCH_OUT(IR_WAKE_MATCH_OUT),
    .IR_DECODER_BUSY_OUT(IR_DECODER_BUSY_OUT));

// file: verif/irwd_ir_src.sv
// behavioural infrared receiver driving both receive inputs
`timescale 1ns/10ps
module irwd_ir_src #(
    parameter int TICK_CYCLES = 4
) (
    input wire logic clk_in,
    input wire logic sel_b_in,
    input wire logic invert_in,
    output logic rx_a_out,
    output logic rx_b_out
);
    logic lvl_ff = 1'b0;
    logic noise_ff = 1'b0;
    // unused input toggles each cycle, so a wrong selection never settles
    always_ff @(posedge clk_in) begin
        noise_ff <= ~noise_ff;
    end
    assign rx_a_out = sel_b_in ? noise_ff : lvl_ff ^ invert_in;
    assign rx_b_out = sel_b_in ? lvl_ff ^ invert_in : noise_ff;
    task automatic seg(input logic l, input int t);
        lvl_ff <= l;
        repeat (t * TICK_CYCLES) @(posedge clk_in);
    endtask
    task automatic send_pd(input logic [7:0] a, input int hdr, input int gap);
        seg(1'b0, 20);
        seg(1'b1, hdr);
        seg(1'b0, gap);
        for (int i = 0; i < 8; i++) begin
            seg(1'b1, 5);
            seg(1'b0, a[i] ? 17 : 6);
        end
        seg(1'b1, 5);
        seg(1'b0, 260);
    endtask
    task automatic send_rc5(input logic [4:0] a, input logic [5:0] c);
        logic [13:0] b;
        logic lv;
        logic nl;
        int n;
        b = {2'b11, 1'b0, a, c};
        seg(1'b0, 20);
        lv = 1'b1;
        n = 1;
        for (int i = 12; i >= 0; i--) begin
            for (int j = 0; j < 2; j++) begin
                nl = j ? b[i] : !b[i];
                if (nl == lv) n++;
                else begin
                    seg(lv, n * 9);
                    lv = nl;
                    n = 1;
                end
            end
        end
        seg(lv, n * 9);
        seg(1'b0, 260);
    endtask
endmodule

// file: verif/irwd_top_tb_top.sv
// self-checking bench of the ir wake decoder
`timescale 1ns/10ps
module irwd_top_tb_top;
    localparam int TICK = 4;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic soft_rst = 1'b0;
    logic ce = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic sel_b = 1'b0;
    logic inv = 1'b0;
    logic rx_a;
    logic rx_b;
    logic [7:0] rdata;
    logic match;
    logic busy;
    logic [31:0] seed = 32'hC9C8AA09;
    int error_cnt = 0;
    int compares = 0;
    int mcnt = 0;
    int cyc = 0;
    logic [7:0] ofs [12] = '{8'h13, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19,
                             8'h1A, 8'h1B, 8'h1C, 8'h1D, 8'h1E, 8'h1F};
    logic [7:0] rstv [12] = '{8'h00, 8'h00, 8'hE0, 8'h00, 8'h10, 8'h14,
                              8'h07, 8'h0B, 8'h50, 8'h64, 8'h28, 8'h32};
    irwd_top #(.TICK_CYCLES(TICK)) irwd_top_i (.CLK_SYS_IN(clk), .RST_N_IN(rst_n),
        .CE_IN(ce), .SOFT_RST_IN(soft_rst), .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata),
        .REG_WR_IN(wr), .REG_RD_IN(rd), .IR_RECEIVE_INPUT_A_IN(rx_a),
        .IR_RECEIVE_INPUT_B_IN(rx_b), .REG_RDATA_OUT(rdata), .IR_WAKE_MATCH_OUT(match),
        .IR_DECODER_BUSY_OUT(busy));
    irwd_ir_src #(.TICK_CYCLES(TICK)) irwd_ir_src_i (.clk_in(clk), .sel_b_in(sel_b),
        .invert_in(inv), .rx_a_out(rx_a), .rx_b_out(rx_b));
    initial begin
        forever #5 clk = ~clk;
    end
    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [7:0] wmask(input logic [7:0] a);
        case (a)
            8'h13: return 8'h3D;
            8'h17: return 8'h00;
            8'h18, 8'h19, 8'h1A, 8'h1B: return 8'h1F;
            default: return 8'hFF;
        endcase
    endfunction
    function automatic logic [7:0] hit(input logic [7:0] c, input logic [7:0] rx,
                                       input logic [7:0] w, input logic [7:0] m);
        return {7'h0, c[0] && !c[5] && (((rx ^ w) & ~m) == 8'h00)};
    endfunction
    task automatic final_report();
        $display("errors=%0d compares=%0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask
    task automatic soft_reset();
        @(posedge clk);
        soft_rst <= 1'b1;
        @(posedge clk);
        soft_rst <= 1'b0;
        for (int i = 0; i < 12; i++) rd_chk(ofs[i], rstv[i]);
    endtask
    task automatic msg(input logic [7:0] c, input logic [7:0] w, input logic [7:0] m,
                       input logic [7:0] a, input int hdr, input int gap, input logic good);
        int m0;
        logic [7:0] rx;
        rx = c[4] ? a : {3'h0, a[4:0]};
        wr_reg(8'h13, c);
        wr_reg(8'h15, w);
        wr_reg(8'h16, m);
        sel_b <= c[3];
        inv <= c[2];
        m0 = mcnt;
        if (c[4]) irwd_ir_src_i.send_pd(a, hdr, gap);
        else irwd_ir_src_i.send_rc5(a[4:0], a[7:2]);
        chk(8'(mcnt - m0), good ? hit(c, rx, w, m) : 8'h00);
        chk({7'h0, busy}, 8'h00);
        if (good) rd_chk(8'h17, rx);
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (match === 1'b1) mcnt <= mcnt + 1;
        if (cyc == 80000) begin
            error_cnt++;
            final_report();
        end
    end
    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        logic [31:0] r;
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 12; i++) rd_chk(ofs[i], rstv[i]);
        for (int i = 0; i < 12; i++) begin
            r = rnd();
            wr_reg(ofs[i], r[7:0]);
            rd_chk(ofs[i], r[7:0] & wmask(ofs[i]));
        end
        wr_reg(8'h14, 8'hFF);
        rd_chk(8'h14, 8'h00);
        rd_chk(8'h20, 8'h00);
        soft_reset();
        // a write while the clock enable is low must not land
        ce <= 1'b0;
        wr_reg(8'h15, 8'h3C);
        ce <= 1'b1;
        rd_chk(8'h15, 8'h00);
        wr_reg(8'h18, 8'h09);
        wr_reg(8'h19, 8'h0D);
        wr_reg(8'h1A, 8'h14);
        wr_reg(8'h1B, 8'h19);
        msg(8'h11, 8'h5A, 8'hFF, 8'hA5, 90, 45, 1'b1);
        msg(8'h10, 8'hA5, 8'h00, 8'hA5, 90, 45, 1'b1);
        msg(8'h11, 8'h00, 8'hFF, 8'h33, 60, 45, 1'b0);
        msg(8'h11, 8'h00, 8'hFF, 8'h33, 90, 30, 1'b0);
        for (int i = 0; i < 8; i++) begin
            r = rnd();
            msg({4'h1, r[3:2], 2'h1}, r[4] ? r[15:8] : r[23:16],
                r[5] ? r[31:24] : 8'h00, r[15:8], 90, 45, 1'b1);
        end
        soft_reset();
        for (int i = 0; i < 4; i++) begin
            r = rnd();
            msg({4'h0, r[3:2], 2'h1}, r[4] ? {3'h0, r[12:8]} : r[31:24],
                8'hE0 | (r[5] ? r[23:16] : 8'h00), r[15:8], 0, 0, 1'b1);
        end
        msg(8'h21, 8'h00, 8'hFF, 8'h00, 0, 0, 1'b0);
        final_report();
    end
endmodule
